// file: lrje_pkg.sv
package lrje_pkg;
  // widths and defaults
  localparam int PC_W = 12;
  localparam int DM_W = 12;
  localparam int CYC_DIV_DEF = 8;
  localparam int CNT_W = 16;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [3:0] REG_RST = 4'h0;
  localparam logic [11:0] BYTES_ONE = 12'h001;
  localparam logic [11:0] BYTES_TWO = 12'h002;

  // machine cycles per instruction
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // working register indices, low register of a pair has bit 0 clear
  localparam logic [2:0] R_A = 3'h0;
  localparam logic [2:0] R_E = 3'h1;
  localparam logic [2:0] R_L = 3'h2;
  localparam logic [2:0] R_H = 3'h3;
  localparam logic [2:0] R_X = 3'h4;
  localparam logic [2:0] R_W = 3'h5;
  localparam logic [1:0] PR_EA = 2'h0;
  localparam logic [1:0] PR_HL = 2'h1;

  // first opcode bytes
  localparam logic [3:0] OPN_JR_BWD = 4'h0;
  localparam logic [3:0] OPN_JR_FWD = 4'h1;
  localparam logic [3:0] OPN_LDA_IM = 4'hb;
  localparam logic [4:0] OP5_LDA_IND = 5'h11;
  localparam logic [4:0] OP5_LDRR_IM = 5'h10;
  localparam logic [7:0] OP_LDA_DA = 8'h8c;
  localparam logic [7:0] OP_STA_DA = 8'h89;
  localparam logic [7:0] OP_STA_HL = 8'hc4;
  localparam logic [7:0] OP_LDEA_DA = 8'hce;
  localparam logic [7:0] OP_STEA_DA = 8'hcd;
  localparam logic [7:0] OP_LDR_IM = 8'hd9;
  localparam logic [7:0] OP_PFX_A = 8'hdd;
  localparam logic [7:0] OP_PFX_EA = 8'hdc;
  localparam logic [7:0] OP_BIT_ST = 8'hfc;
  localparam logic [7:0] OP_BIT_LD = 8'hf4;

  // second opcode bytes
  localparam logic [7:0] OP2_JR_WX = 8'h64;
  localparam logic [7:0] OP2_JR_EA = 8'h60;
  localparam logic [7:0] OP2_LDEA_HL = 8'h08;
  localparam logic [7:0] OP2_STEA_HL = 8'h00;
  localparam logic [4:0] OP25_LDA_R = 5'h01;
  localparam logic [4:0] OP25_STR_A = 5'h00;
  localparam logic [4:0] OP25_LDEA_RR = 5'h1f;
  localparam logic [4:0] OP25_STRR_EA = 5'h1e;

  // indirect pair select codes
  localparam logic [2:0] IND_HL = 3'h5;
  localparam logic [2:0] IND_WX = 3'h6;
  localparam logic [2:0] IND_WL = 3'h7;

  // bit operand forms and address pages
  localparam logic [3:0] BIT_PTR_TAG = 4'h4;
  localparam logic [1:0] BIT_FB_TAG = 2'h2;
  localparam logic [1:0] BIT_FF_TAG = 2'h3;
  localparam logic [5:0] PTR_PAGE = 6'h3f;
  localparam logic [7:0] FB_PAGE = 8'hfb;
  localparam logic [7:0] FF_PAGE = 8'hff;
  localparam logic [3:0] LOW_BANK = 4'h0;

  typedef enum logic [2:0] {
    S_WAIT = 3'b000,
    S_OP1 = 3'b001,
    S_OP2 = 3'b010,
    S_EXEC = 3'b011,
    S_M0 = 3'b100,
    S_M1 = 3'b101
  } lrje_state_t;

  typedef enum logic [1:0] {
    G_NONE = 2'b00,
    G_ACC = 2'b01,
    G_HLP = 2'b10
  } lrje_grp_t;

  typedef enum logic [4:0] {
    K_NOP = 5'b00000, K_JR_IM = 5'b00001, K_JR_WX = 5'b00010,
    K_JR_EA = 5'b00011, K_LDA_IM = 5'b00100, K_LDA_IND = 5'b00101,
    K_LDA_DA = 5'b00110, K_LDA_R = 5'b00111, K_LDR_IM = 5'b01000,
    K_LDRR_IM = 5'b01001, K_STA_DA = 5'b01010, K_STR_A = 5'b01011,
    K_LDEA_HL = 5'b01100, K_LDEA_DA = 5'b01101, K_LDEA_RR = 5'b01110,
    K_STA_HL = 5'b01111, K_STEA_DA = 5'b10000, K_STRR_EA = 5'b10001,
    K_STEA_HL = 5'b10010, K_BIT_ST = 5'b10011, K_BIT_LD = 5'b10100
  } lrje_op_t;
endpackage

// file: lrje_tick.sv
`timescale 1ns/10ps
// machine cycle enable: one clock wide pulse every div clocks
module lrje_tick #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;

  // free running divider, the pulse is registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= 1'b0;
    end
  end
endmodule // lrje_tick

// file: lrje_bitsel.sv
`timescale 1ns/10ps
// picks one bit of a nibble and forms the nibble with that bit replaced
module lrje_bitsel (
  input wire logic [3:0] nib_in,
  input wire logic [1:0] sel,
  input wire logic bit_in,
  output logic bit_out,
  output logic [3:0] nib_out
);
  always_comb begin
    nib_out = nib_in;
    nib_out[sel] = bit_in;
    bit_out = nib_in[sel];
  end
endmodule // lrje_bitsel

// file: lrje_exec.sv
`timescale 1ns/10ps
module lrje_exec #(
  parameter int CYC_DIV = lrje_pkg::CYC_DIV_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] PMEM_DATA,
  input wire logic [3:0] DMEM_RDATA,
  output logic [lrje_pkg::PC_W-1:0] PMEM_ADDR,
  output logic [lrje_pkg::DM_W-1:0] DMEM_ADDR,
  output logic [3:0] DMEM_WDATA,
  output logic DMEM_WE,
  output logic [lrje_pkg::PC_W-1:0] PC,
  output logic CARRY,
  output logic [3:0] ACC,
  output logic [3:0] ACC_EXT,
  output logic INSTR_DONE
);
  import lrje_pkg::*;

  lrje_state_t state_q;
  lrje_grp_t prev_q;
  lrje_grp_t grp;
  lrje_op_t op;
  logic [3:0] regs_q [8];
  logic [7:0] op1_q;
  logic [7:0] op2_q;
  logic [11:0] pc_q;
  logic [11:0] start_q;
  logic [1:0] cyc_q;
  logic [1:0] ncyc_q;
  logic started_q;
  logic tick;
  logic start_now;
  logic suppress;
  logic mem_op;
  logic [11:0] maddr;
  logic [1:0] bsel;
  logic [1:0] mv_p;
  logic [1:0] im_p;
  logic [7:0] ind_pair;
  logic [7:0] mv_val;
  logic [7:0] im_val;
  logic [7:0] hl_ptr;
  logic [7:0] ea_val;
  logic bit_rd;
  logic [3:0] nib_wr;
  logic [31:0] reg_vec;
  logic [CNT_W-1:0] clk_cnt_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // opcodes that carry a second byte
  function automatic logic is_two(input logic [7:0] b);
    is_two = (b == OP_LDA_DA) || (b == OP_STA_DA) || (b == OP_PFX_A) ||
      (b == OP_PFX_EA) || (b == OP_LDR_IM) || (b == OP_LDEA_DA) ||
      (b == OP_STEA_DA) || (b == OP_BIT_ST) || (b == OP_BIT_LD) ||
      (b[7:3] == OP5_LDRR_IM && b[0]);
  endfunction

  // out of scope codes decode as no_operation of their own length
  function automatic lrje_op_t op_of(input logic [7:0] b1,
                                     input logic [7:0] b2);
    op_of = K_NOP;
    if (b1[7:4] == OPN_JR_BWD || b1[7:4] == OPN_JR_FWD) begin
      op_of = K_JR_IM;
    end else if (b1[7:4] == OPN_LDA_IM) begin
      op_of = K_LDA_IM;
    end else if (b1 == OP_LDA_DA) begin
      op_of = K_LDA_DA;
    end else if (b1 == OP_STA_DA) begin
      op_of = K_STA_DA;
    end else if (b1[7:3] == OP5_LDA_IND && (b1[2:0] == IND_HL ||
                 b1[2:0] == IND_WX || b1[2:0] == IND_WL)) begin
      op_of = K_LDA_IND;
    end else if (b1[7:3] == OP5_LDRR_IM && b1[0]) begin
      op_of = K_LDRR_IM;
    end else if (b1 == OP_STA_HL) begin
      op_of = K_STA_HL;
    end else if (b1 == OP_LDEA_DA) begin
      op_of = K_LDEA_DA;
    end else if (b1 == OP_STEA_DA) begin
      op_of = K_STEA_DA;
    end else if (b1 == OP_LDR_IM) begin
      op_of = K_LDR_IM;
    end else if (b1 == OP_BIT_ST) begin
      op_of = K_BIT_ST;
    end else if (b1 == OP_BIT_LD) begin
      op_of = K_BIT_LD;
    end else if (b1 == OP_PFX_A) begin
      if (b2 == OP2_JR_WX) op_of = K_JR_WX;
      else if (b2 == OP2_JR_EA) op_of = K_JR_EA;
      else if (b2[7:3] == OP25_LDA_R) op_of = K_LDA_R;
      else if (b2[7:3] == OP25_STR_A) op_of = K_STR_A;
    end else if (b1 == OP_PFX_EA) begin
      if (b2 == OP2_LDEA_HL) op_of = K_LDEA_HL;
      else if (b2 == OP2_STEA_HL) op_of = K_STEA_HL;
      else if (b2[7:3] == OP25_LDEA_RR && !b2[0]) op_of = K_LDEA_RR;
      else if (b2[7:3] == OP25_STRR_EA && !b2[0]) op_of = K_STRR_EA;
    end
  endfunction

  function automatic logic [1:0] cyc_of(input lrje_op_t k);
    case (k)
      K_JR_WX, K_JR_EA: cyc_of = CYC_THREE;
      K_NOP, K_LDA_IM, K_LDA_IND, K_STA_HL: cyc_of = CYC_ONE;
      default: cyc_of = CYC_TWO;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // decode of the latched opcode bytes
  assign op = op_of(op1_q, op2_q);
  assign mv_p = op2_q[2:1];
  assign im_p = op1_q[2:1];
  assign mv_val = {regs_q[{mv_p, 1'b1}], regs_q[{mv_p, 1'b0}]};
  assign im_val = {regs_q[{im_p, 1'b1}], regs_q[{im_p, 1'b0}]};
  assign hl_ptr = {regs_q[R_H], regs_q[R_L]};
  assign ea_val = {regs_q[R_E], regs_q[R_A]};

  // indirect pair choice for the accumulator load
  always_comb begin
    if (op1_q[2:0] == IND_WX) ind_pair = {regs_q[R_W], regs_q[R_X]};
    else if (op1_q[2:0] == IND_WL) ind_pair = {regs_q[R_W], regs_q[R_L]};
    else ind_pair = hl_ptr;
  end

  // immediate load kind, only accumulator and pointer pair repeat
  always_comb begin
    grp = G_NONE;
    if (op == K_LDA_IM) grp = G_ACC;
    else if (op == K_LDRR_IM && im_p == PR_EA) grp = G_ACC;
    else if (op == K_LDRR_IM && im_p == PR_HL) grp = G_HLP;
  end
  assign suppress = (grp != G_NONE) && (grp == prev_q);

  // data memory address and bit number for each form
  always_comb begin
    maddr = {LOW_BANK, op2_q};
    bsel = op2_q[5:4];
    mem_op = 1'b1;
    case (op)
      K_LDA_IND: maddr = {LOW_BANK, ind_pair};
      K_STA_HL: maddr = {LOW_BANK, hl_ptr};
      K_LDEA_HL, K_STEA_HL: maddr = {LOW_BANK, hl_ptr[7:1], 1'b0};
      K_LDEA_DA, K_STEA_DA: maddr = {LOW_BANK, op2_q[7:1], 1'b0};
      K_LDA_DA, K_STA_DA: maddr = {LOW_BANK, op2_q};
      K_BIT_ST, K_BIT_LD: begin
        if (op2_q[7:4] == BIT_PTR_TAG) begin
          maddr = {PTR_PAGE, op2_q[3:0], regs_q[R_L][3:2]};
          bsel = regs_q[R_L][1:0];
        end else if (op2_q[7:6] == BIT_FB_TAG) begin
          maddr = {FB_PAGE, op2_q[3:0]};
        end else if (op2_q[7:6] == BIT_FF_TAG) begin
          maddr = {FF_PAGE, op2_q[3:0]};
        end else begin
          maddr = {LOW_BANK, regs_q[R_H], op2_q[3:0]};
        end
      end
      default: mem_op = 1'b0;
    endcase
  end

  // bit pick and insert against the nibble being read
  lrje_bitsel u_bitsel (
    .nib_in(DMEM_RDATA),
    .sel(bsel),
    .bit_in(CARRY),
    .bit_out(bit_rd),
    .nib_out(nib_wr)
  );

  //////////////////////////////////////////////////////////////////////////
  // machine cycle timing
  lrje_tick #(.DIV(CYC_DIV)) u_tick (
    .clk(CLK_SYS),
    .rst(RST),
    .tick(tick)
  );

  // next instruction starts on the tick that closes the last cycle
  assign start_now = (state_q == S_WAIT) && tick &&
    ((cyc_q + 2'h1) >= ncyc_q);

  // ticks seen since the current instruction began
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      cyc_q <= 2'h0;
    end else if (start_now) begin
      cyc_q <= 2'h0;
    end else if (tick && cyc_q != CYC_THREE) begin
      cyc_q <= cyc_q + 2'h1;
    end
  end

  // completion pulse, none before the first instruction ran
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      started_q <= 1'b0;
      INSTR_DONE <= 1'b0;
    end else begin
      INSTR_DONE <= start_now && started_q;
      if (start_now) started_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer, program counter and fetch
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= S_WAIT;
      pc_q <= PC_RST;
      start_q <= PC_RST;
      PMEM_ADDR <= PC_RST;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
      ncyc_q <= CYC_ONE;
      prev_q <= G_NONE;
    end else begin
      case (state_q)
        S_WAIT: begin
          if (start_now) begin
            state_q <= S_OP1;
            PMEM_ADDR <= pc_q;
            start_q <= pc_q;
          end
        end
        S_OP1: begin
          op1_q <= PMEM_DATA;
          pc_q <= pc_q + BYTES_ONE;
          PMEM_ADDR <= pc_q + BYTES_ONE;
          state_q <= is_two(PMEM_DATA) ? S_OP2 : S_EXEC;
        end
        S_OP2: begin
          op2_q <= PMEM_DATA;
          pc_q <= pc_q + BYTES_ONE;
          state_q <= S_EXEC;
        end
        S_EXEC: begin
          ncyc_q <= cyc_of(op);
          prev_q <= grp;
          if (op == K_JR_IM && op1_q[4]) begin
            pc_q <= pc_q + {8'h00, op1_q[3:0]};
          end else if (op == K_JR_IM) begin
            pc_q <= start_q - {8'h00, op1_q[3:0]};
          end else if (op == K_JR_WX) begin
            // pc already past the second byte, so page wrap follows
            pc_q <= {pc_q[11:8], regs_q[R_W], regs_q[R_X]};
          end else if (op == K_JR_EA) begin
            pc_q <= {pc_q[11:8], ea_val};
          end
          state_q <= mem_op ? S_M0 : S_WAIT;
        end
        S_M0: begin
          if (op == K_LDEA_HL || op == K_LDEA_DA || op == K_STEA_HL ||
              op == K_STEA_DA || op == K_BIT_ST) begin
            state_q <= S_M1;
          end else begin
            state_q <= S_WAIT;
          end
        end
        S_M1: state_q <= S_WAIT;
        default: state_q <= S_WAIT;
      endcase
    end
  end
  assign PC = pc_q;

  //////////////////////////////////////////////////////////////////////////
  // working registers; memory data lands one clock after the address
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) regs_q[i] <= REG_RST;
    end else if (state_q == S_EXEC && !suppress) begin
      case (op)
        K_LDA_IM: regs_q[R_A] <= op1_q[3:0];
        K_LDA_R: regs_q[R_A] <= regs_q[op2_q[2:0]];
        K_LDR_IM: regs_q[op2_q[2:0]] <= op2_q[7:4];
        K_STR_A: regs_q[op2_q[2:0]] <= regs_q[R_A];
        K_LDRR_IM: begin
          regs_q[{im_p, 1'b0}] <= op2_q[3:0];
          regs_q[{im_p, 1'b1}] <= op2_q[7:4];
        end
        K_LDEA_RR: begin
          regs_q[R_A] <= regs_q[{mv_p, 1'b0}];
          regs_q[R_E] <= regs_q[{mv_p, 1'b1}];
        end
        K_STRR_EA: begin
          regs_q[{mv_p, 1'b1}] <= regs_q[R_E];
          regs_q[{mv_p, 1'b0}] <= regs_q[R_A];
        end
        default: ;
      endcase
    end else if (state_q == S_M0 && (op == K_LDA_IND || op == K_LDA_DA ||
                 op == K_LDEA_HL || op == K_LDEA_DA)) begin
      regs_q[R_A] <= DMEM_RDATA;
    end else if (state_q == S_M1 && (op == K_LDEA_HL ||
                 op == K_LDEA_DA)) begin
      regs_q[R_E] <= DMEM_RDATA;
    end
  end
  assign ACC = regs_q[R_A];
  assign ACC_EXT = regs_q[R_E];
  always_comb begin
    for (int i = 0; i < 8; i++) reg_vec[i*4 +: 4] = regs_q[i];
  end

  // carry flag, only the bit move toward carry touches it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CARRY <= 1'b0;
    end else if (state_q == S_M0 && op == K_BIT_LD) begin
      CARRY <= bit_rd;
    end
  end

  // data memory port; a bit store is read, merge, write back
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DMEM_ADDR <= 12'h000;
      DMEM_WDATA <= 4'h0;
      DMEM_WE <= 1'b0;
    end else if (state_q == S_EXEC && mem_op) begin
      DMEM_ADDR <= maddr;
      DMEM_WDATA <= regs_q[R_A];
      DMEM_WE <= (op == K_STA_DA) || (op == K_STA_HL) ||
        (op == K_STEA_DA) || (op == K_STEA_HL);
    end else if (state_q == S_M0) begin
      DMEM_WE <= 1'b0;
      if (op == K_LDEA_HL || op == K_LDEA_DA) begin
        DMEM_ADDR[0] <= 1'b1;
      end else if (op == K_STEA_HL || op == K_STEA_DA) begin
        DMEM_ADDR[0] <= 1'b1;
        DMEM_WDATA <= regs_q[R_E];
        DMEM_WE <= 1'b1;
      end else if (op == K_BIT_ST) begin
        DMEM_WDATA <= nib_wr;
        DMEM_WE <= 1'b1;
      end
    end else begin
      DMEM_WE <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // clocks per instruction, watched by the timing check only
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) clk_cnt_q <= '0;
    else if (start_now) clk_cnt_q <= '0;
    else clk_cnt_q <= clk_cnt_q + CNT_W'(1);
  end

  sequence s_wr_acc;
    DMEM_WE && !DMEM_ADDR[0] && DMEM_WDATA == regs_q[R_A];
  endsequence
  sequence s_wr_ext;
    DMEM_WE && DMEM_ADDR[0] && DMEM_WDATA == regs_q[R_E];
  endsequence

  a_jr_span: assert property (state_q == S_EXEC && op == K_JR_IM |=>
    (pc_q - start_q) <= 12'h010 || (pc_q - start_q) >= 12'hff1)
    else $error("relative jump target out of span");
  a_jr_quiet: assert property (state_q == S_EXEC && op == K_JR_IM |=>
    reg_vec == $past(reg_vec) && $stable(CARRY) && !DMEM_WE)
    else $error("relative jump changed state");
  a_jr_low: assert property (state_q == S_EXEC && op == K_JR_EA |=>
    pc_q[7:0] == $past(ea_val) && pc_q[11:8] == $past(pc_q[11:8]))
    else $error("indexed jump target wrong");
  a_jr_page: assert property (state_q == S_EXEC && op == K_JR_WX |=>
    pc_q[11:8] == $past(start_q[11:8], 1) + 4'(start_q[7:1] == 7'h7f))
    else $error("indexed jump page wrong");
  a_src_kept: assert property (state_q == S_EXEC && op == K_STR_A |=>
    regs_q[R_A] == $past(regs_q[R_A]))
    else $error("load source altered");
  a_redund_nop: assert property (state_q == S_EXEC && suppress |=>
    reg_vec == $past(reg_vec) ##1 prev_q != G_NONE)
    else $error("suppressed load changed registers");
  a_pair_only: assert property (state_q == S_EXEC && op == K_LDRR_IM &&
    im_p[1] |=> im_val == $past(op2_q))
    else $error("work pair immediate was suppressed");
  a_ind_addr: assert property (state_q == S_EXEC && op == K_LDA_IND |=>
    DMEM_ADDR[7:0] == $past(ind_pair) && !DMEM_WE)
    else $error("indirect load address wrong");
  a_imm_pair: assert property (state_q == S_EXEC && op == K_LDRR_IM &&
    !suppress |=> im_val == $past(op2_q))
    else $error("byte immediate not stored");
  a_pair_rd: assert property (state_q == S_M0 && op == K_LDEA_HL |=>
    regs_q[R_A] == $past(DMEM_RDATA) ##1 regs_q[R_E] == $past(DMEM_RDATA))
    else $error("pair load data wrong");
  a_ptr_even: assert property (state_q == S_EXEC && (op == K_LDEA_HL ||
    op == K_STEA_HL) |=> !DMEM_ADDR[0] && hl_ptr == $past(hl_ptr))
    else $error("pointer pair address not even");
  a_pair_wr: assert property (state_q == S_EXEC && op == K_STEA_HL |=>
    s_wr_acc ##1 s_wr_ext)
    else $error("pair store order wrong");
  a_da_pair: assert property (state_q == S_EXEC && op == K_STEA_DA |=>
    s_wr_acc ##0 DMEM_ADDR[7:1] == $past(op2_q[7:1]) ##1 s_wr_ext)
    else $error("direct pair store wrong");
  a_mv_in: assert property (state_q == S_EXEC && op == K_LDEA_RR |=>
    ea_val == $past(mv_val))
    else $error("pair to accumulator pair move wrong");
  a_mv_out: assert property (state_q == S_EXEC && op == K_STRR_EA |=>
    mv_val == $past(ea_val))
    else $error("accumulator pair to pair move wrong");
  a_cyc_len: assert property (start_now && started_q |->
    int'(clk_cnt_q) + 1 == int'(ncyc_q) * CYC_DIV)
    else $error("instruction cycle count wrong");
  a_bit_keep: assert property (state_q == S_EXEC && op == K_BIT_LD |=>
    !DMEM_WE [*2])
    else $error("bit load wrote memory");
  a_bit_ptr: assert property (state_q == S_EXEC && op == K_BIT_ST &&
    op2_q[7:4] == BIT_PTR_TAG |=>
    DMEM_ADDR == {PTR_PAGE, $past(op2_q[3:0]), $past(regs_q[R_L][3:2])})
    else $error("pointer bit address wrong");
  a_bit_len: assert property (state_q == S_EXEC && (op == K_BIT_LD ||
    op == K_BIT_ST) |-> pc_q == start_q + BYTES_TWO ##1 ncyc_q == CYC_TWO)
    else $error("bit move length wrong");
  a_sup_len: assert property (state_q == S_EXEC && suppress |->
    pc_q == start_q + (op == K_LDA_IM ? BYTES_ONE : BYTES_TWO))
    else $error("suppressed load length wrong");
endmodule // lrje_exec

// file: test_load_and_relative_jump_exec.sv
`timescale 1ns/10ps
module test_load_and_relative_jump_exec;
  import lrje_pkg::*;
  localparam int DIV = 6;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic [7:0] pm [4096];
  logic [3:0] dm [4096];
  logic [7:0] PMEM_DATA;
  logic [3:0] DMEM_RDATA;
  logic [11:0] PMEM_ADDR;
  logic [11:0] DMEM_ADDR;
  logic [3:0] DMEM_WDATA;
  logic DMEM_WE;
  logic [11:0] PC;
  logic CARRY;
  logic [3:0] ACC;
  logic [3:0] ACC_EXT;
  logic INSTR_DONE;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h5219;
  logic [3:0] im_a;
  logic [7:0] im_ea;
  logic [3:0] d24;
  logic [3:0] d25;
  logic [3:0] d34;
  int n_done;
  int gap;
  //////////////////////////////////////////////////////////////////////////
  // clock and memories; reads are combinational, as the fetch path expects
  always #5 CLK_SYS = ~CLK_SYS;
  assign PMEM_DATA = pm[PMEM_ADDR];
  assign DMEM_RDATA = dm[DMEM_ADDR];
  always @(posedge CLK_SYS) begin
    if (DMEM_WE === 1'b1) begin
      dm[DMEM_ADDR] <= DMEM_WDATA;
    end
  end
  // completion pulses, and clocks from the first pulse to the tenth
  always @(posedge CLK_SYS) begin
    if (RST) begin
      n_done <= 0;
      gap <= 0;
    end else begin
      if (INSTR_DONE === 1'b1) n_done <= n_done + 1;
      if (n_done >= 1 && n_done < 10) gap <= gap + 1;
    end
  end
  lrje_exec #(.CYC_DIV(DIV)) dut_u (.CLK_SYS(CLK_SYS), .RST(RST),
    .PMEM_DATA(PMEM_DATA), .DMEM_RDATA(DMEM_RDATA), .PMEM_ADDR(PMEM_ADDR),
    .DMEM_ADDR(DMEM_ADDR), .DMEM_WDATA(DMEM_WDATA), .DMEM_WE(DMEM_WE),
    .PC(PC), .CARRY(CARRY), .ACC(ACC), .ACC_EXT(ACC_EXT),
    .INSTR_DONE(INSTR_DONE));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t nibble got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp12(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t address got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // a hang anywhere ends the run through the same closing task
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////
  // each pass: fresh reset, random operands, one program of two legs joined by a relative jump
  initial begin
    for (int run = 0; run < 3; run++) begin
      @(posedge CLK_SYS);
      RST <= 1'b1;
      seed = xs(seed);
      im_a = seed[3:0];
      im_ea = {1'b1, seed[14:12], ~seed[3:0]};
      {d24, d25, d34} = seed[27:16];
      for (int i = 0; i < 4096; i++) begin
        pm[i] = 8'h00;
        dm[i] = seed[7:4] ^ i[3:0];
      end
      dm[12'h024] = d24;
      dm[12'h025] = d25;
      dm[12'h034] = d34;
      // suppressed pair immediate sits right after the nibble immediate
      {pm[0], pm[1], pm[2], pm[3], pm[4]} = {4'hb, im_a, 8'h81, im_ea, 16'h8337};
      {pm[5], pm[6], pm[7], pm[8]} = 32'hdc00_ce25;
      {pm[9], pm[10], pm[11]} = 24'hf4241a;
      // second leg: store A, reload through second work pair, indexed jump
      {pm[22], pm[23], pm[24], pm[25]} = 32'h8940_8534;
      {pm[26], pm[27], pm[28]} = 24'h8edd64;
      repeat (10) @(posedge CLK_SYS);
      RST <= 1'b0;
      for (int k = 0; k < 600 && PC !== 12'h034; k++) begin
        @(negedge CLK_SYS);
      end
      cmp12(PC, 12'h034);
      cmp12(12'(gap), 12'(17 * DIV));
      cmp4(4'(n_done), 4'ha);
      cmp4(dm[12'h036], im_a);
      cmp4(dm[12'h037], 4'h0);
      cmp4(dm[12'h040], d24);
      cmp4(ACC, d34);
      cmp4(ACC_EXT, d25);
      cmp4(dm[12'h024], d24);
      cmp4({3'h0, CARRY}, {3'h0, d34[2]});
      $display("pass %0d done, mismatches so far %0d", run, num_errors);
    end
    report_and_stop();
  end
endmodule // test_load_and_relative_jump_exec
